// ===== dv/fetc_line_coder_assertions.sv
// Purpose: concurrent checks on the line coder ports
// Assumes: one clock domain, synchronous active-low reset
// Notes: receive checks hold only with the descrambler bypassed
module fetc_chk (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic tx_en,
    input wire logic enc_bypass,
    input wire logic scr_bypass,
    input wire logic [4:0] tx_pair_pos,
    input wire logic [4:0] tx_pair_neg,
    input wire logic [4:0] rx_code,
    input wire logic descr_bypass,
    input wire logic dec_bypass,
    input wire logic [3:0] rx_nibble,
    input wire logic rx_code_err,
    input wire logic rx_idle,
    input wire logic rx_locked
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // reset sampled too: the edge that releases reset still clears the receive outputs
    wire logic plain_rx = rst_n && descr_bypass && !dec_bypass;
    wire logic [4:0] lv = tx_pair_pos | tx_pair_neg;

    a_pair_excl: assert property ((tx_pair_pos & tx_pair_neg) == 5'h00)
        else $error("both stream halves high");
    // plain idle is all ones, so the line level must flip on every bit
    a_idle_fill: assert property ((scr_bypass && !enc_bypass && !tx_en) [*4]
        |=> (lv == 5'h15 || lv == 5'h0A)) else $error("idle line not toggling");
    a_rx_idle: assert property (plain_rx && rx_code == 5'h1F
        |=> rx_idle && rx_nibble == 4'h0 && !rx_code_err) else $error("idle decode wrong");
    a_rx_start: assert property (plain_rx && (rx_code == 5'h18 || rx_code == 5'h11)
        |=> rx_nibble == 4'h5 && !rx_idle) else $error("start pair decode wrong");
    a_rx_end: assert property (plain_rx && (rx_code == 5'h0D || rx_code == 5'h07)
        |=> rx_nibble == 4'h0 && !rx_code_err) else $error("end pair decode wrong");
    a_rx_halt: assert property (plain_rx && rx_code == 5'h04
        |=> rx_code_err && !rx_idle) else $error("halt not flagged");
    a_dec_pass: assert property (rst_n && descr_bypass && dec_bypass
        |=> {1'b0, rx_nibble} == ($past(rx_code) & 5'h0F) && !rx_code_err)
        else $error("decoder bypass wrong");
    a_lock_byp: assert property (descr_bypass [*2] |-> rx_locked)
        else $error("bypass not locked");
endmodule // fetc_chk

bind fetc_line_coder fetc_chk u_chk (.ref_clk, .rst_n, .tx_en, .enc_bypass, .scr_bypass,
    .tx_pair_pos, .tx_pair_neg, .rx_code, .descr_bypass, .dec_bypass, .rx_nibble,
    .rx_code_err, .rx_idle, .rx_locked);

// ===== dv/fetc_line_coder_bench.sv
// Purpose: self-checking bench of the transmit line coder
// Assumes: scrambler bypassed except in the key stream and seed tests
// Notes: a falling-edge monitor turns the line back into code-groups
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin num_errors++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end

module fetc_line_coder_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
        5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    logic ref_clk = 0, rst_n = 0, go = 0, tx_en, tx_er, busy, last_lvl = 0;
    logic enc_bypass = 0, scr_bypass = 1, descr_bypass = 1, dec_bypass = 0;
    logic rx_code_err, rx_idle, rx_locked;
    logic [3:0] txd, rx_nibble;
    logic [4:0] rx_code = 5'h1F, straps = 5'h0A, tx_pair_pos, tx_pair_neg, lv, cg, q[$];
    logic [7:0] len = 8'h12, err_at = 8'hFF;
    int num_errors = 0, cmp_count = 0, cyc = 0;

    fetc_mac_model i_mac (.ref_clk, .go, .len, .err_at, .txd, .tx_en, .tx_er, .busy);
    fetc_line_coder i_dut (.ref_clk, .rst_n, .txd, .tx_en, .tx_er, .enc_bypass, .scr_bypass,
        .station_address_straps(straps), .tx_pair_pos, .tx_pair_neg, .rx_code,
        .descr_bypass, .dec_bypass, .rx_nibble, .rx_code_err, .rx_idle, .rx_locked);

    initial forever #20 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 2000) begin
            num_errors++;
            close_out();
        end
    end

    // undo NRZI: a level change is a one
    always @(negedge ref_clk) begin
        lv = tx_pair_pos | tx_pair_neg;
        cg = lv ^ {last_lvl, lv[4:1]};
        last_lvl = lv[0];
        q.push_back(cg);
    end

    task automatic close_out();
        if (num_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic t_idle();
        repeat (10) @(posedge ref_clk);
        `CHK("idle_after_reset", 5'h1F, q[$])
    endtask

    // mid-run reset with new straps; the key must start from {6'h3F, straps}
    task automatic t_seed();
        logic [10:0] l = {6'h3F, 5'h15};
        logic [4:0] k;
        straps <= 5'h15;
        scr_bypass <= 0;
        rst_n <= 0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1;
        repeat (6) @(posedge ref_clk);
        q.delete();
        repeat (4) @(posedge ref_clk);
        for (int g = 0; g < 4; g++) begin
            for (int b = 4; b >= 0; b--) begin
                k[b] = l[10] ^ l[8];
                l = {l[9:0], k[b]};
            end
            `CHK("seeded_group", 5'h1F ^ k, q[g])
        end
        scr_bypass <= 1;
        repeat (4) @(posedge ref_clk);
    endtask

    // scrambled idle from an independent key stream; lock needs 12 clean idle groups
    task automatic t_lock();
        logic [10:0] l = 11'h155;
        logic [4:0] c;
        @(posedge ref_clk);
        descr_bypass <= 0;
        dec_bypass <= 0;
        for (int g = 0; g < 20; g++) begin
            for (int b = 4; b >= 0; b--) begin
                c[b] = ~(l[10] ^ l[8]);
                l = {l[9:0], ~c[b]};
            end
            rx_code <= c;
            @(negedge ref_clk);
            if (g == 2) `CHK("rx_unlocked", 1'b0, rx_locked)
            @(posedge ref_clk);
        end
        #1;
        `CHK("rx_locked", 1'b1, rx_locked)
        `CHK("rx_descr_idle", 1'b1, rx_idle)
        `CHK("rx_descr_err", 1'b0, rx_code_err)
        `CHK("rx_descr_nibble", 4'h0, rx_nibble)
    endtask

    task automatic t_frame(input logic [7:0] n, input logic [7:0] e);
        logic [4:0] exp[$];
        int k;
        exp = '{5'h18, 5'h11};
        for (int i = 2; i < n; i++) exp.push_back(i == e ? 5'h04 : ENC[i % 16]);
        exp = {exp, 5'h0D, 5'h07, 5'h1F, 5'h1F};
        q.delete();
        len <= n;
        err_at <= e;
        go <= 1;
        @(posedge ref_clk);
        go <= 0;
        @(posedge ref_clk);
        for (k = 0; k < 300 && busy !== 1'b0; k++) @(posedge ref_clk);
        repeat (6) @(posedge ref_clk);
        k = 0;
        while (k < q.size() && q[k] !== 5'h18) k++;
        foreach (exp[i]) `CHK("code_group", exp[i], q[k + i])
    endtask

    task automatic t_scr();
        logic [39:0] kb;
        logic [10:0] l;
        int bad = 0;
        scr_bypass <= 0;
        repeat (4) @(posedge ref_clk);
        q.delete();
        repeat (8) @(posedge ref_clk);
        for (int g = 0; g < 8; g++) kb = {kb[34:0], q[g] ^ 5'h1F};
        l = kb[39:29];
        for (int b = 28; b >= 0; b--) begin
            if ((l[10] ^ l[8]) !== kb[b]) bad++;
            l = {l[9:0], kb[b]};
        end
        `CHK("key_mismatches", 0, bad)
        `CHK("key_present", 1'b1, |kb)
        scr_bypass <= 1;
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic t_enc();
        enc_bypass <= 1;
        repeat (3) @(posedge ref_clk);
        q.delete();
        repeat (4) @(posedge ref_clk);
        for (int k = 1; k < 4; k++) `CHK("raw_group", {1'b0, ~q[k - 1][3:0]}, q[k])
        enc_bypass <= 0;
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic t_rx();
        logic [4:0] c;
        logic [3:0] en;
        logic ee;
        for (int i = 0; i < 32; i++) begin
            c = i;
            {ee, en} = 5'h10;
            for (int d = 0; d < 16; d++) if (ENC[d] == c) {ee, en} = {1'b0, 4'(d)};
            if (c == 5'h18 || c == 5'h11) {ee, en} = 5'h05;
            if (c == 5'h1F || c == 5'h0D || c == 5'h07) ee = 0;
            @(posedge ref_clk);
            rx_code <= c;
            @(posedge ref_clk);
            #1;
            `CHK("rx_err", ee, rx_code_err)
            `CHK("rx_idle", c == 5'h1F, rx_idle)
            if (!ee) `CHK("rx_nibble", en, rx_nibble)
        end
        @(posedge ref_clk);
        dec_bypass <= 1;
        rx_code <= 5'h13;
        @(posedge ref_clk);
        #1;
        `CHK("rx_raw", 4'h3, rx_nibble)
        `CHK("rx_locked", 1'b1, rx_locked)
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1;
        t_idle();
        t_frame(8'h12, 8'hFF);
        t_frame(8'h06, 8'h03);
        t_scr();
        t_enc();
        t_seed();
        t_rx();
        t_lock();
        close_out();
    end
endmodule // fetc_line_coder_bench

// ===== dv/fetc_mac_model.sv
// Purpose: transmit side of a MAC feeding nibbles to the line coder
// Assumes: nibble i of a frame carries i, error flagged at one index
// Notes: between frames the data lines wander, as a released bus would
module fetc_mac_model (
    input wire logic ref_clk,
    input wire logic go,
    input wire logic [7:0] len,
    input wire logic [7:0] err_at,
    output logic [3:0] txd = 4'h0,
    output logic tx_en = 1'b0,
    output logic tx_er = 1'b0,
    output logic busy = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] n = 8'h00;

    always @(posedge ref_clk) begin
        if (busy && n == len) begin
            busy <= 0;
            tx_en <= 0;
            tx_er <= 0;
            txd <= ~txd;
        end else if (busy || go) begin
            busy <= 1;
            tx_en <= 1;
            txd <= busy ? n[3:0] : 4'h0;
            tx_er <= (busy ? n : 8'h00) == err_at;
            n <= busy ? n + 8'h01 : 8'h01;
        end else
            txd <= ~txd;
    end
endmodule // fetc_mac_model

// ===== rtl/fetc_dec5b.v
// Purpose: 5B code-group to 4B nibble lookup for the receive bypass path
// Assumes: aligned code-group input, purely combinational
// Notes: bypass passes the low four code bits through unchanged
`include "fetc_defs.vh"

module fetc_dec5b (
    code,
    bypass,
    nibble,
    is_idle,
    bad
);
    input wire [4:0] code;
    input wire bypass;
    output reg [3:0] nibble;
    output reg is_idle;
    output reg bad;

    always @* begin
        nibble = 4'h0;
        is_idle = 1'b0;
        bad = 1'b0;
        case (code)
            5'h1E: nibble = 4'h0;
            5'h09: nibble = 4'h1;
            5'h14: nibble = 4'h2;
            5'h15: nibble = 4'h3;
            5'h0A: nibble = 4'h4;
            5'h0B: nibble = 4'h5;
            5'h0E: nibble = 4'h6;
            5'h0F: nibble = 4'h7;
            5'h12: nibble = 4'h8;
            5'h13: nibble = 4'h9;
            5'h16: nibble = 4'hA;
            5'h17: nibble = 4'hB;
            5'h1A: nibble = 4'hC;
            5'h1B: nibble = 4'hD;
            5'h1C: nibble = 4'hE;
            5'h1D: nibble = 4'hF;
            `FETC_CG_I: begin
                nibble = `FETC_NIB_IDLE; // R6
                is_idle = 1'b1;
            end
            `FETC_CG_J: nibble = `FETC_NIB_SSD; // R6
            `FETC_CG_K: nibble = `FETC_NIB_SSD; // R6
            `FETC_CG_T: nibble = `FETC_NIB_ESD; // R6
            `FETC_CG_R: nibble = `FETC_NIB_ESD; // R6
            default: bad = 1'b1; // R5
        endcase
        if (bypass) begin
            nibble = code[3:0]; // R15
            is_idle = 1'b0;
            bad = 1'b0;
        end
    end
endmodule // fetc_dec5b

// ===== rtl/fetc_defs.vh
// Purpose: constants of the 100 Mb/s transmit line coder and its receive bypass path
// Assumes: one 25 MHz clock, five serial bits handled per clock, first bit in bit 4
// Notes: included by fetc_line_coder.v and fetc_dec5b.v
// What this block does
// R1: data nibbles map to fixed 5-bit code-groups
// R2: frame starts with J then K pair
// R3: TX_EN falling appends T then R pair
// R4: idle code-groups fill until next frame
// R5: halt code-group marks error, never data
// R6: decode idle and T/R to 0000, J/K to 0101
// R7: closed-loop 11-bit LFSR scrambler runs continuously
// R8: each NRZ bit XORed with scrambler output
// R9: scrambler seed taken from station address straps
// R10: scrambled stream is NRZI encoded
// R11: NRZI ones alternate onto two output streams
// R12: outputs carry only MLT-3, no binary mode
// R13: five serial bits per nibble clock period
// R14: encoder and scrambler each have a bypass
// R15: descrambler and decoder each have a bypass
// R16: nibble clock 25 MHz, MAC synchronous to it
// R17: NRZI toggles on one, holds on zero
// R18: idle sent after reset before first frame
`ifndef FETC_DEFS_VH
`define FETC_DEFS_VH

`define FETC_CG_I 5'h1F
`define FETC_CG_J 5'h18
`define FETC_CG_K 5'h11
`define FETC_CG_T 5'h0D
`define FETC_CG_R 5'h07
`define FETC_CG_H 5'h04

`define FETC_NIB_IDLE 4'h0
`define FETC_NIB_SSD 4'h5
`define FETC_NIB_ESD 4'h0

`define FETC_ST_IDLE 2'h0
`define FETC_ST_SSDK 2'h1
`define FETC_ST_DATA 2'h2
`define FETC_ST_ESDR 2'h3

// upper scrambler seed bits; nonzero so the seed is never all zero
`define FETC_SEED_HI 6'h3F
`define FETC_LFSR_RST 11'h7FF
`define FETC_STRAP_WAIT 3'h4
`define FETC_LOCK_GROUPS 4'hC

`endif

// ===== rtl/fetc_line_coder.v
// Purpose: 4B/5B encode, scramble, NRZI and MLT-3 split of the 100 Mb/s transmit path
// Assumes: MAC nibble interface synchronous to ref_clk; straps are asynchronous pins
// Notes: five serial bits per clock leave in parallel, bit 4 is the first on the wire
`include "fetc_defs.vh"

module fetc_line_coder (
    ref_clk,
    rst_n,
    txd,
    tx_en,
    tx_er,
    enc_bypass,
    scr_bypass,
    station_address_straps,
    tx_pair_pos,
    tx_pair_neg,
    rx_code,
    descr_bypass,
    dec_bypass,
    rx_nibble,
    rx_code_err,
    rx_idle,
    rx_locked
);
    input wire ref_clk;
    input wire rst_n;
    input wire [3:0] txd;
    input wire tx_en;
    input wire tx_er;
    input wire enc_bypass;
    input wire scr_bypass;
    input wire [4:0] station_address_straps;
    output wire [4:0] tx_pair_pos;
    output wire [4:0] tx_pair_neg;
    input wire [4:0] rx_code;
    input wire descr_bypass;
    input wire dec_bypass;
    output wire [3:0] rx_nibble;
    output wire rx_code_err;
    output wire rx_idle;
    output wire rx_locked;

    reg [4:0] strap_s1_q, strap_s2_q, strap_s3_q, strap_q;
    reg [2:0] wait_q;
    reg seeded_q;
    reg [1:0] st_q, st_d;
    reg [4:0] code_q, code_d;
    reg [10:0] lfsr_q, lfsr_d;
    reg nrzi_q, nrzi_d;
    reg ph_q, ph_d;
    reg [4:0] pos_q, pos_d, neg_q, neg_d;
    reg [10:0] rlfsr_q, rlfsr_d;
    reg [3:0] lock_cnt_q, lock_cnt_d;
    reg [4:0] ud_d;
    reg match_d;
    reg [3:0] rx_nib_q;
    reg rx_err_q, rx_idle_q;
    wire [3:0] dec_nib;
    wire dec_idle, dec_bad;
    reg fb, sbit, key, pred;
    integer i;
    integer j;

    function [4:0] enc4b5b;
        input [3:0] n;
        begin
            case (n)
                4'h0: enc4b5b = 5'h1E;
                4'h1: enc4b5b = 5'h09;
                4'h2: enc4b5b = 5'h14;
                4'h3: enc4b5b = 5'h15;
                4'h4: enc4b5b = 5'h0A;
                4'h5: enc4b5b = 5'h0B;
                4'h6: enc4b5b = 5'h0E;
                4'h7: enc4b5b = 5'h0F;
                4'h8: enc4b5b = 5'h12;
                4'h9: enc4b5b = 5'h13;
                4'hA: enc4b5b = 5'h16;
                4'hB: enc4b5b = 5'h17;
                4'hC: enc4b5b = 5'h1A;
                4'hD: enc4b5b = 5'h1B;
                4'hE: enc4b5b = 5'h1C;
                default: enc4b5b = 5'h1D;
            endcase
        end
    endfunction

    // straps pass three flops; a value counts once stages two and three agree
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            strap_s1_q <= 5'h00;
            strap_s2_q <= 5'h00;
            strap_s3_q <= 5'h00;
            strap_q <= 5'h00;
            wait_q <= 3'h0;
            seeded_q <= 1'b0;
        end else begin
            strap_s1_q <= station_address_straps;
            strap_s2_q <= strap_s1_q;
            strap_s3_q <= strap_s2_q;
            if (strap_s2_q == strap_s3_q) begin
                strap_q <= strap_s3_q;
            end
            if (wait_q != `FETC_STRAP_WAIT) begin
                wait_q <= wait_q + 3'h1;
            end else begin
                seeded_q <= 1'b1;
            end
        end
    end

    // code-group sequencer: one code-group per nibble clock
    always @* begin
        st_d = st_q;
        code_d = `FETC_CG_I; // R4 R18
        if (!seeded_q) begin
            st_d = `FETC_ST_IDLE; // R18
        end else if (enc_bypass) begin
            st_d = `FETC_ST_IDLE;
            code_d = {tx_er, txd}; // R14
        end else begin
            case (st_q)
                `FETC_ST_IDLE: begin
                    if (tx_en) begin
                        code_d = `FETC_CG_J; // R2
                        st_d = `FETC_ST_SSDK;
                    end
                end
                `FETC_ST_SSDK: begin
                    code_d = `FETC_CG_K; // R2
                    st_d = `FETC_ST_DATA;
                end
                `FETC_ST_DATA: begin
                    if (!tx_en) begin
                        code_d = `FETC_CG_T; // R3
                        st_d = `FETC_ST_ESDR;
                    end else if (tx_er) begin
                        code_d = `FETC_CG_H; // R5
                    end else begin
                        code_d = enc4b5b(txd); // R1 R16
                    end
                end
                `FETC_ST_ESDR: begin
                    code_d = `FETC_CG_R; // R3
                    st_d = `FETC_ST_IDLE;
                end
                default: st_d = `FETC_ST_IDLE;
            endcase
        end
    end

    // scramble, NRZI and MLT-3 split over the five bits of one code-group
    always @* begin
        lfsr_d = lfsr_q;
        nrzi_d = nrzi_q;
        ph_d = ph_q;
        pos_d = 5'h00;
        neg_d = 5'h00;
        fb = 1'b0;
        sbit = 1'b0;
        for (i = 4; i >= 0; i = i - 1) begin
            fb = lfsr_d[10] ^ lfsr_d[8]; // R7
            lfsr_d = {lfsr_d[9:0], fb}; // R7 R13
            sbit = code_q[i] ^ (fb & ~scr_bypass); // R8 R14
            if (sbit) begin
                nrzi_d = ~nrzi_d; // R10 R17
                // a falling NRZI edge ends one mark, so the next goes to the other side
                if (!nrzi_d) begin
                    ph_d = ~ph_d; // R11
                end
            end
            pos_d[i] = nrzi_d & ~ph_d; // R11 R12
            neg_d[i] = nrzi_d & ph_d; // R11 R12
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= `FETC_ST_IDLE;
            code_q <= `FETC_CG_I; // R18
            lfsr_q <= `FETC_LFSR_RST;
            nrzi_q <= 1'b0;
            ph_q <= 1'b0;
            pos_q <= 5'h00;
            neg_q <= 5'h00;
        end else begin
            st_q <= st_d;
            code_q <= code_d;
            nrzi_q <= nrzi_d;
            ph_q <= ph_d;
            pos_q <= pos_d;
            neg_q <= neg_d;
            if (seeded_q) begin
                lfsr_q <= lfsr_d; // R7
            end else begin
                lfsr_q <= {`FETC_SEED_HI, strap_q}; // R9
            end
        end
    end

    assign tx_pair_pos = pos_q;
    assign tx_pair_neg = neg_q;

    // receive side: descrambler locks by assuming scrambled idle until it predicts the key
    always @* begin
        rlfsr_d = rlfsr_q;
        ud_d = 5'h00;
        match_d = 1'b1;
        pred = 1'b0;
        key = 1'b0;
        for (j = 4; j >= 0; j = j - 1) begin
            pred = rlfsr_d[10] ^ rlfsr_d[8];
            if (pred != ~rx_code[j]) begin
                match_d = 1'b0;
            end
            key = rx_locked ? pred : ~rx_code[j];
            rlfsr_d = {rlfsr_d[9:0], key};
            ud_d[j] = descr_bypass ? rx_code[j] : (rx_code[j] ^ key); // R15
        end
        lock_cnt_d = lock_cnt_q;
        if (!rx_locked) begin
            lock_cnt_d = match_d ? (lock_cnt_q + 4'h1) : 4'h0;
        end
    end

    fetc_dec5b u_dec (
        .code(ud_d),
        .bypass(dec_bypass),
        .nibble(dec_nib),
        .is_idle(dec_idle),
        .bad(dec_bad)
    );

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            rlfsr_q <= `FETC_LFSR_RST;
            lock_cnt_q <= 4'h0;
            rx_nib_q <= 4'h0;
            rx_err_q <= 1'b0;
            rx_idle_q <= 1'b0;
        end else begin
            rlfsr_q <= rlfsr_d;
            lock_cnt_q <= lock_cnt_d;
            rx_nib_q <= dec_nib; // R6
            rx_err_q <= dec_bad; // R5
            rx_idle_q <= dec_idle;
        end
    end

    // lock holds until reset; there is no loss-of-sync timer in this path
    assign rx_locked = descr_bypass | (lock_cnt_q == `FETC_LOCK_GROUPS);
    assign rx_nibble = rx_nib_q;
    assign rx_code_err = rx_err_q;
    assign rx_idle = rx_idle_q;
endmodule // fetc_line_coder
